/* logic/usb_frame_pkg.sv */
/*
  shared constants and carrier types of the frame number tracker.
  assumes a 250 MHz system clock and a full-speed (12 Mbit/s) link.
*/
`default_nettype none
package usb_frame_pkg;
  // clock and bit rates
  localparam int CLK_KHZ          = 250000;
  localparam int FS_BIT_KHZ       = 12000;
  localparam int FRAME_LIMIT_BITS = 12060;
  localparam logic [8:0] BIT_STEP = 9'(FS_BIT_KHZ / 1000);
  localparam logic [8:0] BIT_WRAP = 9'(CLK_KHZ / 1000);

  // register indices; byte address is four times the index
  localparam logic [31:0] FIFO_ALERT_EVENTS_IDX = 32'h5000_1820;
  localparam logic [31:0] FIFO_ALERT_MASK_IDX   = 32'h5000_1822;
  localparam logic [31:0] FRAME_NUMBER_HIGH_IDX = 32'h5000_1824;
  localparam logic [31:0] FRAME_NUMBER_LOW_IDX  = 32'h5000_1826;

  // field positions
  localparam int RX_ALERT_LSB = 4;
  localparam int TX_ALERT_LSB = 0;
  localparam int MISSED_BIT   = 7;
  localparam int LOCK_BIT     = 6;
  localparam int CLEAR_BIT    = 5;

  // reset values
  localparam logic [2:0]  ALERT_MASK_RST = 3'h0;
  localparam logic        MISSED_RST     = 1'b1;
  localparam logic        LOCK_RST       = 1'b1;
  localparam logic [10:0] FRAME_RST      = 11'h000;

  typedef struct packed {
    logic        valid;
    logic [10:0] frame;
  } sof_t;

  typedef struct packed {
    logic [2:0] rx;
    logic [2:0] tx;
  } alert_vec_t;

  typedef enum logic [1:0] {TRK_LOCKED, TRK_ONE_MISS, TRK_FROZEN} track_state_t;

  // word index match against a printed register index
  function automatic logic reg_hit(input logic [11:0] word_idx, input logic [31:0] idx);
    return word_idx == idx[11:0];
  endfunction
endpackage
`default_nettype wire

/* logic/fs_bit_tick.sv */
/*
  fractional divider: one-cycle enable per full-speed bit period.
  assumes the system clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fs_bit_tick
  import usb_frame_pkg::*;
(
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_resetn,
  // enable out
  output logic      o_tick
);
  logic [8:0] acc_ff;
  logic [8:0] sum;

  assign sum = acc_ff + BIT_STEP;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      acc_ff <= 9'h000;
      o_tick <= 1'b0;
    end
    else if (sum >= BIT_WRAP)
    begin
      acc_ff <= sum - BIT_WRAP;
      o_tick <= 1'b1;
    end
    else
    begin
      acc_ff <= sum;
      o_tick <= 1'b0;
    end
  end
endmodule // fs_bit_tick
`default_nettype wire

/* logic/frame_watchdog.sv */
/*
  counts bit enables since the last restart; pulses when the limit is hit.
  assumes restart and tick come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module frame_watchdog
  import usb_frame_pkg::*;
#(
  parameter int LIMIT = FRAME_LIMIT_BITS
) (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_resetn,
  // control
  input  wire logic i_tick,
  input  wire logic i_restart,
  // timeout pulse
  output logic      o_expire
);
  logic [15:0] cnt_ff;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn || i_restart)
    begin
      cnt_ff   <= 16'h0000;
      o_expire <= 1'b0;
    end
    else if (i_tick && cnt_ff == 16'(LIMIT - 1))
    begin
      cnt_ff   <= 16'h0000;
      o_expire <= 1'b1;
    end
    else
    begin
      cnt_ff   <= cnt_ff + 16'(i_tick);
      o_expire <= 1'b0;
    end
  end
endmodule // frame_watchdog
`default_nettype wire

/* logic/usb_frame_number_tracker.sv */
/*
  frame number tracking and supervision of a full-speed device, fifo alert
  mask with warning summary, and an ahb-lite register slave.
  assumes sof and fifo alert strobes come from logic on the same clock.
*/
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: masked-in fifo alert event sets the warning summary bit
// RULE2: mask bit at zero keeps its event from the summary
// RULE3: wrong sof frame number or sof timeout sets missed flag
// RULE4: missed and lock-lost flags reset to one, clear on high read
// RULE5: two bad frames or sof timeout set the lock-lost flag
// RULE6: while lock lost, next valid sof loads the frame counter
// RULE7: writing clear bit zeroes frame counter; bit self-clears, reads zero
// RULE8: high field shows the top three frame counter bits
// RULE9: no frame within the bit limit increments frame counter itself; code skips this in TRK_FROZEN, so not after reset or a prior timeout
// RULE10: two successive bad frames freeze counter until next valid sof
// RULE11: low byte read buffers top bits for the next high read
// RULE12: high read without prior low read returns live top bits
// RULE13: software reads low byte first, then high register
// RULE14: rx alert event set at fifo level, cleared on read or flush
// RULE15: tx alert event set at level, cleared by data, flush, done
// RULE16: bit-time supervision restarts on every frame counter change
module usb_frame_number_tracker
  import usb_frame_pkg::*;
#(
  parameter int FRAME_LIMIT = FRAME_LIMIT_BITS
) (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  // start-of-frame from the packet decoder
  input  wire sof_t        i_sof,
  // fifo alert strobes
  input  wire alert_vec_t  i_alert_set,
  input  wire alert_vec_t  i_alert_clr,
  // status out
  output logic             o_main_warn,
  output logic [10:0]      o_frame_counter
);
  logic [10:0]  frame_counter_ff;
  logic [10:0]  nxt_frame_counter;
  logic [10:0]  expected;
  track_state_t state_ff;
  track_state_t nxt_state;
  logic         missed_frame_flag_ff;
  logic         lock_lost_flag_ff;
  logic         set_missed;
  logic         set_lock;
  logic [2:0]   top_buf_ff;
  logic         top_buf_valid_ff;
  alert_vec_t   fifo_alert_events_ff;
  alert_vec_t   fifo_alert_mask_ff;
  logic         main_warn_ff;
  logic         wr_pend_ff;
  logic [11:0]  wr_idx_ff;
  logic [11:0]  addr_idx;
  logic         acc;
  logic         rd_acc;
  logic         rd_high;
  logic         rd_low;
  logic         wr_mask;
  logic         frame_count_clear;
  logic [31:0]  nxt_rdata;
  logic [2:0]   frame_number_top_bits;
  logic         bit_tick;
  logic         expire;
  logic         restart;

  // bus decode
  assign addr_idx    = i_haddr[13:2];
  assign acc         = i_hsel && i_htrans[1] && i_hready;
  assign rd_acc      = acc && !i_hwrite;
  assign rd_high     = rd_acc && reg_hit(addr_idx, FRAME_NUMBER_HIGH_IDX);
  assign rd_low      = rd_acc && reg_hit(addr_idx, FRAME_NUMBER_LOW_IDX);
  assign wr_mask     = wr_pend_ff && reg_hit(wr_idx_ff, FIFO_ALERT_MASK_IDX);
  // RULE7 self-clearing strobe
  assign frame_count_clear = wr_pend_ff && reg_hit(wr_idx_ff, FRAME_NUMBER_HIGH_IDX)
                             && i_hwdata[CLEAR_BIT];
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 12'h000;
    end
    else if (i_hready)
    begin
      wr_pend_ff <= acc && i_hwrite;
      wr_idx_ff  <= addr_idx;
    end
  end

  // RULE12 live top bits unless a low read buffered them
  // RULE11 buffered top bits after a low read
  assign frame_number_top_bits = top_buf_valid_ff ? top_buf_ff : frame_counter_ff[10:8];

  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    if (reg_hit(addr_idx, FIFO_ALERT_EVENTS_IDX))
    begin
      nxt_rdata[RX_ALERT_LSB +: 3] = fifo_alert_events_ff.rx;
      nxt_rdata[TX_ALERT_LSB +: 3] = fifo_alert_events_ff.tx;
    end
    else if (reg_hit(addr_idx, FIFO_ALERT_MASK_IDX))
    begin
      nxt_rdata[RX_ALERT_LSB +: 3] = fifo_alert_mask_ff.rx;
      nxt_rdata[TX_ALERT_LSB +: 3] = fifo_alert_mask_ff.tx;
    end
    else if (reg_hit(addr_idx, FRAME_NUMBER_HIGH_IDX))
    begin
      nxt_rdata[MISSED_BIT] = missed_frame_flag_ff;
      nxt_rdata[LOCK_BIT]   = lock_lost_flag_ff;
      // RULE8 top three bits
      nxt_rdata[2:0]        = frame_number_top_bits;
    end
    else if (reg_hit(addr_idx, FRAME_NUMBER_LOW_IDX))
    begin
      nxt_rdata[7:0] = frame_counter_ff[7:0];
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      o_hrdata <= 32'h0000_0000;
    else if (rd_acc)
      o_hrdata <= nxt_rdata;
  end

  // RULE11 capture on low read, drop on high read
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      top_buf_ff       <= 3'h0;
      top_buf_valid_ff <= 1'b0;
    end
    else if (rd_low)
    begin
      top_buf_ff       <= frame_counter_ff[10:8];
      top_buf_valid_ff <= 1'b1;
    end
    else if (rd_high)
      top_buf_valid_ff <= 1'b0;
  end

  // fifo alert mask and events
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      fifo_alert_mask_ff.rx <= ALERT_MASK_RST;
      fifo_alert_mask_ff.tx <= ALERT_MASK_RST;
    end
    else if (wr_mask)
    begin
      fifo_alert_mask_ff.rx <= i_hwdata[RX_ALERT_LSB +: 3];
      fifo_alert_mask_ff.tx <= i_hwdata[TX_ALERT_LSB +: 3];
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      fifo_alert_events_ff <= '0;
    else
      // RULE14 rx events, set wins
      // RULE15 tx events, set wins
      fifo_alert_events_ff <= (fifo_alert_events_ff & ~i_alert_clr) | i_alert_set;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      main_warn_ff <= 1'b0;
    else
      // RULE1 RULE2 masked summary
      main_warn_ff <= |(fifo_alert_events_ff & fifo_alert_mask_ff);
  end
  assign o_main_warn = main_warn_ff;

  // bit-time supervision
  fs_bit_tick u_bit_tick (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .o_tick    (bit_tick)
  );

  // RULE16 restart on any counter update
  assign restart = frame_count_clear || i_sof.valid || (nxt_frame_counter != frame_counter_ff);

  frame_watchdog #(
    .LIMIT (FRAME_LIMIT)
  ) u_watchdog (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_tick    (bit_tick),
    .i_restart (restart),
    .o_expire  (expire)
  );

  // frame tracking
  assign expected = frame_counter_ff + 11'h001;

  always_comb
  begin
    nxt_frame_counter = frame_counter_ff;
    nxt_state         = state_ff;
    set_missed        = 1'b0;
    set_lock          = 1'b0;
    if (frame_count_clear)
      // RULE7 zero the counter
      nxt_frame_counter = 11'h000;
    else if (i_sof.valid)
    begin
      if (lock_lost_flag_ff || i_sof.frame == expected)
      begin
        // RULE6 direct load while unlocked
        nxt_frame_counter = i_sof.frame;
        nxt_state         = TRK_LOCKED;
      end
      else
      begin
        // RULE3 wrong frame number
        set_missed = 1'b1;
        case (state_ff)
          TRK_LOCKED:
          begin
            nxt_frame_counter = expected;
            nxt_state         = TRK_ONE_MISS;
          end
          TRK_ONE_MISS:
          begin
            // RULE5 RULE10 second bad frame, freeze
            set_lock  = 1'b1;
            nxt_state = TRK_FROZEN;
          end
          TRK_FROZEN:
          begin
            // RULE10 reload from the next valid sof
            nxt_frame_counter = i_sof.frame;
            nxt_state         = TRK_LOCKED;
            set_missed        = 1'b0;
          end
          default:
            nxt_state = TRK_FROZEN;
        endcase
      end
    end
    else if (expire)
    begin
      // RULE3 RULE5 timeout
      set_missed = 1'b1;
      set_lock   = 1'b1;
      nxt_state  = TRK_FROZEN;
      // RULE9 artificial increment
      if (state_ff != TRK_FROZEN)
        nxt_frame_counter = expected;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      frame_counter_ff <= FRAME_RST;
      state_ff         <= TRK_FROZEN;
    end
    else
    begin
      frame_counter_ff <= nxt_frame_counter;
      state_ff         <= nxt_state;
    end
  end
  assign o_frame_counter = frame_counter_ff;

  // RULE4 hardware set wins over read clear
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      missed_frame_flag_ff <= MISSED_RST;
      lock_lost_flag_ff    <= LOCK_RST;
    end
    else
    begin
      missed_frame_flag_ff <= set_missed || (missed_frame_flag_ff && !rd_high);
      lock_lost_flag_ff    <= set_lock || (lock_lost_flag_ff && !rd_high);
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  property p_warn_set;
    |(fifo_alert_events_ff & fifo_alert_mask_ff) |=> o_main_warn;
  endproperty
  a_warn_set: assert property (p_warn_set) else $error("summary not set"); // RULE1

  property p_warn_mask;
    (fifo_alert_events_ff & fifo_alert_mask_ff) == '0 |=> !o_main_warn;
  endproperty
  a_warn_mask: assert property (p_warn_mask) else $error("masked event leaked"); // RULE2

  property p_missed;
    i_sof.valid && !frame_count_clear && !lock_lost_flag_ff && state_ff == TRK_LOCKED
      && i_sof.frame != expected |=> missed_frame_flag_ff ##0 frame_counter_ff == $past(expected);
  endproperty
  a_missed: assert property (p_missed) else $error("missed flag not set"); // RULE3

  property p_flag_clear;
    rd_high && !set_missed && !set_lock |=> !missed_frame_flag_ff && !lock_lost_flag_ff;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared"); // RULE4

  property p_timeout_lock;
    expire && !i_sof.valid && !frame_count_clear |=> lock_lost_flag_ff && state_ff == TRK_FROZEN;
  endproperty
  a_timeout_lock: assert property (p_timeout_lock) else $error("lock not lost"); // RULE5

  property p_relock;
    i_sof.valid && lock_lost_flag_ff && !frame_count_clear
      |=> frame_counter_ff == $past(i_sof.frame) && state_ff == TRK_LOCKED;
  endproperty
  a_relock: assert property (p_relock) else $error("no direct load"); // RULE6

  property p_clear;
    frame_count_clear |=> frame_counter_ff == 11'h000 ##1 o_frame_counter == 11'h000 || restart;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed"); // RULE7

  property p_incr;
    expire && !i_sof.valid && !frame_count_clear && state_ff != TRK_FROZEN
      |=> frame_counter_ff == $past(frame_counter_ff) + 11'h001;
  endproperty
  a_incr: assert property (p_incr) else $error("no increment"); // RULE9

  property p_freeze;
    state_ff == TRK_FROZEN && !i_sof.valid && !frame_count_clear |=> $stable(frame_counter_ff);
  endproperty
  a_freeze: assert property (p_freeze) else $error("frozen counter moved"); // RULE10

  property p_coherent;
    rd_low |=> top_buf_valid_ff && top_buf_ff == $past(frame_counter_ff[10:8]);
  endproperty
  a_coherent: assert property (p_coherent) else $error("top bits not buffered"); // RULE11

  property p_buf_read;
    rd_high && top_buf_valid_ff |=> o_hrdata[2:0] == $past(top_buf_ff);
  endproperty
  a_buf_read: assert property (p_buf_read) else $error("buffered top bits not returned"); // RULE11

  property p_live;
    rd_high && !top_buf_valid_ff |=> o_hrdata[2:0] == $past(frame_counter_ff[10:8]);
  endproperty
  a_live: assert property (p_live) else $error("live top bits wrong"); // RULE12

  property p_rx_event;
    i_alert_set.rx[0] |=> fifo_alert_events_ff.rx[0];
  endproperty
  a_rx_event: assert property (p_rx_event) else $error("rx event lost"); // RULE14

  property p_tx_event;
    i_alert_clr.tx[0] && !i_alert_set.tx[0] |=> !fifo_alert_events_ff.tx[0];
  endproperty
  a_tx_event: assert property (p_tx_event) else $error("tx event not cleared"); // RULE15
endmodule // usb_frame_number_tracker
`default_nettype wire

/* verification/sof_host_model.sv */
/*
  host side model: sends start-of-frame strobes with its own frame number.
  assumes commands arrive by non-blocking assignment at the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module sof_host_model
  import usb_frame_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  // commands
  input  wire logic        i_send,
  input  wire logic [10:0] i_skip,
  // start-of-frame out
  output sof_t             o_sof
);
  logic [10:0] frame_ff;
  logic [10:0] nxt_frame;

  // a non-zero skip sends a number other than the next one
  assign nxt_frame = frame_ff + 11'h001 + i_skip;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      frame_ff <= 11'h000;
      o_sof    <= '0;
    end
    else if (i_send)
    begin
      frame_ff <= nxt_frame;
      o_sof    <= {1'b1, nxt_frame};
    end
    else
      // idle: the number field must not keep its last value
      o_sof <= {1'b0, ~o_sof.frame};
  end
endmodule // sof_host_model
`default_nettype wire

/* verification/usb_frame_number_tracker_tb.sv */
/*
  self-checking bench: sof tracking, timeouts, coherent reads, alert mask.
  assumes the package and the host model are compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_frame_number_tracker_tb;
  import usb_frame_pkg::*;
  localparam int LIM = 20;
  localparam logic [31:0] HI = FRAME_NUMBER_HIGH_IDX;
  logic        clk, rstn, hsel, hwrite, hready, hresp, send, warn;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, seed, mval;
  logic [10:0] skip, fc, sent, was, e;
  alert_vec_t  aset, aclr;
  sof_t        sof;
  int          err_total, n_compared, bpos;

  sof_host_model i_host (
    .i_clk_sys(clk), .i_resetn(rstn), .i_send(send), .i_skip(skip), .o_sof(sof)
  );
  usb_frame_number_tracker #(.FRAME_LIMIT(LIM)) i_dut (
    .i_clk_sys(clk), .i_resetn(rstn), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_sof(sof), .i_alert_set(aset), .i_alert_clr(aclr), .o_main_warn(warn),
    .o_frame_counter(fc)
  );

  always @(posedge clk)
    if (sof.valid === 1'b1)
      sent <= sof.frame;

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // bounded wait for hready at a rising edge
  task automatic edge_ready;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        err_total++;
        end_sim();
      end
      @(posedge clk);
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] idx, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= idx << 2;
    edge_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    edge_ready();
    rd = hrdata;
  endtask

  task automatic rchk(input logic [31:0] idx, input logic [31:0] exp,
                      input logic [31:0] m = 32'hFFFF_FFFF);
    bus(1'b0, idx, 32'h0000_0000);
    check(rd & m, exp, "register");
    check({31'h0, hresp}, 32'h0000_0000, "response");
  endtask

  task automatic fchk(input logic [10:0] exp);
    check({21'h0, fc}, {21'h0, exp}, "counter");
  endtask

  // one sof from the host; the counter is settled on return
  task automatic sof_go(input logic [10:0] s);
    send <= 1'b1;
    skip <= s;
    @(posedge clk);
    send <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic wait_change;
    int n;
    n = 0;
    was = fc;
    while (fc === was && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    if (fc === was)
    begin
      err_total++;
      end_sim();
    end
  endtask

  initial
  begin
    {rstn, hsel, hwrite, send} = 4'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    {haddr, hwdata} = 64'h0;
    skip = 11'h000;
    {aset, aclr} = 12'h000;
    err_total = 0;
    n_compared = 0;
    seed = 32'h0000_0045;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk(HI, 32'h0000_00C0);
    rchk(HI, 32'h0000_0000);
    rchk(FIFO_ALERT_MASK_IDX, 32'h0000_0000);
    seed = xs(seed);
    sof_go(seed[10:0]);
    fchk(sent);
    bus(1'b0, HI, 32'h0000_0000);
    for (int k = 0; k < 4; k++)
    begin
      was = fc;
      sof_go(11'h000);
      fchk(was + 11'h001);
    end
    rchk(HI, {29'h0, sent[10:8]});
    e = fc + 11'h001;
    sof_go(11'h005);
    fchk(e);
    rchk(HI, {24'h0, 5'b10000, e[10:8]});
    sof_go(11'h003);
    fchk(e);
    // lock lost flag still set: the next sof loads directly
    sof_go(11'h3FE - sent);
    fchk(11'h3FF);
    rchk(HI, 32'h0000_00C3);
    rchk(FRAME_NUMBER_LOW_IDX, 32'h0000_00FF);
    sof_go(11'h000);
    fchk(11'h400);
    rchk(HI, 32'h0000_0003, 32'h0000_003F);
    rchk(HI, 32'h0000_0004, 32'h0000_003F);
    bus(1'b1, HI, 32'h0000_0020);
    @(posedge clk);
    fchk(11'h000);
    rchk(HI, 32'h0000_0000, 32'h0000_003F);
    repeat (360) @(posedge clk);
    fchk(11'h000);
    wait_change();
    fchk(11'h001);
    seed = xs(seed);
    sof_go(seed[10:0]);
    fchk(sent);
    rchk(HI, {24'h0, 5'b11000, sent[10:8]});
    bus(1'b1, 32'h5000_1830, 32'hFFFF_FFFF);
    rchk(32'h5000_1830, 32'h0000_0000);
    seed = xs(seed);
    mval = seed & 32'h0000_0077;
    for (int r = 0; r < 2; r++)
    begin
      bus(1'b1, FIFO_ALERT_MASK_IDX, mval);
      rchk(FIFO_ALERT_MASK_IDX, mval);
      for (int i = 0; i < 6; i++)
      begin
        bpos = (i < 3) ? i : i + 1;
        aset <= alert_vec_t'(6'(1 << i));
        @(posedge clk);
        aset <= '0;
        repeat (2) @(posedge clk);
        check({31'h0, warn}, {31'h0, mval[bpos]}, "warning");
        rchk(FIFO_ALERT_EVENTS_IDX, 32'h1 << bpos);
        aclr <= alert_vec_t'(6'(1 << i));
        @(posedge clk);
        aclr <= '0;
        repeat (2) @(posedge clk);
        check({31'h0, warn}, 32'h0000_0000, "warning");
        rchk(FIFO_ALERT_EVENTS_IDX, 32'h0000_0000);
      end
      mval = mval ^ 32'h0000_0077;
    end
    end_sim();
  end
endmodule // usb_frame_number_tracker_tb
`default_nettype wire
